/* File: common/hrap_consts.vh */
// Purpose: shared constants of the host RAM access port
// Assumes: included by bare name from every core file
// Notes: offsets are byte addresses on the register bus
`ifndef HRAP_CONSTS_VH
`define HRAP_CONSTS_VH

// widths and depths (module parameter defaults; the axi address width sizes ports directly)
`define HRAP_DATA_W 16
`define HRAP_ADDR_W 8
`define HRAP_CNT_W 8
`define HRAP_FIFO_DEPTH 8
`define HRAP_FIFO_PW 3
`define HRAP_AXI_AW 5

// register byte offsets
`define HRAP_REG_CTRL 5'h00
`define HRAP_REG_STAT 5'h04
`define HRAP_REG_RADDR 5'h08
`define HRAP_REG_RDATA 5'h0c

// register fields and reset values
`define HRAP_CTRL_EN 0
`define HRAP_CTRL_EN_RST 1'b1
`define HRAP_STAT_MODE 0
`define HRAP_STAT_BUSY 1
`define HRAP_STAT_FEMPTY 2
`define HRAP_STAT_PTR_LSB 8

// allocated i/o word fields
`define HRAP_W1_DIR 0
`define HRAP_W1_WDONE 6
`define HRAP_W1_RDONE 7
`define HRAP_W1_ADDR_LSB 8
`define HRAP_W3_RDONE 6
`define HRAP_W3_WDONE 7

// bus responses
`define HRAP_RESP_OKAY 2'b00
`define HRAP_RESP_SLVERR 2'b10

`endif

/* File: core/hrap_fifo.v */
// Purpose: write-data buffer between the block port and the engine
// Assumes: depth is a power of two, PW = log2(DEPTH)
// Notes: read side is first-word fall-through
`timescale 1ns/1ps
`include "hrap_consts.vh"
module hrap_fifo #(
  parameter DW = `HRAP_DATA_W,
  parameter DEPTH = `HRAP_FIFO_DEPTH,
  parameter PW = `HRAP_FIFO_PW
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_resetn,
  // fill side
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [DW-1:0] i_in_data,
  // drain side
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [DW-1:0] o_out_data
);

localparam [PW:0] FULL_CNT = DEPTH[PW:0];

reg [DW-1:0] buf_r [0:DEPTH-1];
reg [PW-1:0] wr_ptr_r;
reg [PW-1:0] rd_ptr_r;
reg [PW:0] cnt_r;
wire push;
wire pop;

assign o_in_ready = (cnt_r != FULL_CNT);
assign o_out_valid = (cnt_r != {(PW+1){1'b0}});
assign o_out_data = buf_r[rd_ptr_r];
assign push = i_in_valid && o_in_ready;
assign pop = o_out_valid && i_out_ready;

always @(posedge i_clk_sys) begin
  if (push) begin
    buf_r[wr_ptr_r] <= i_in_data;
  end
end

always @(posedge i_clk_sys) begin
  if (!i_resetn) begin
    wr_ptr_r <= {PW{1'b0}};
    rd_ptr_r <= {PW{1'b0}};
    cnt_r <= {(PW+1){1'b0}};
  end else begin
    if (push) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
    case ({push, pop})
      2'b10: cnt_r <= cnt_r + 1'b1;
      2'b01: cnt_r <= cnt_r - 1'b1;
      default: cnt_r <= cnt_r;
    endcase
  end
end

endmodule

/* File: core/hrap_ram.v */
// Purpose: internal parameter/data ram with two synchronous ports
// Assumes: one-cycle read latency on both ports
// Notes: on a same-address write collision port a wins
`timescale 1ns/1ps
`include "hrap_consts.vh"
module hrap_ram #(
  parameter DW = `HRAP_DATA_W,
  parameter AW = `HRAP_ADDR_W
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_resetn,
  // port a: host access engines
  input wire i_a_we,
  input wire [AW-1:0] i_a_addr,
  input wire [DW-1:0] i_a_wdata,
  output reg [DW-1:0] o_a_rdata,
  // port b: register bus window
  input wire i_b_we,
  input wire [AW-1:0] i_b_addr,
  input wire [DW-1:0] i_b_wdata,
  output reg [DW-1:0] o_b_rdata
);

reg [DW-1:0] mem_r [0:(1<<AW)-1];

always @(posedge i_clk_sys) begin
  if (i_b_we && !(i_a_we && (i_a_addr == i_b_addr))) begin
    mem_r[i_b_addr] <= i_b_wdata;
  end
  if (i_a_we) begin
    mem_r[i_a_addr] <= i_a_wdata;
  end
end

always @(posedge i_clk_sys) begin
  if (!i_resetn) begin
    o_a_rdata <= {DW{1'b0}};
    o_b_rdata <= {DW{1'b0}};
  end else begin
    o_a_rdata <= mem_r[i_a_addr];
    o_b_rdata <= mem_r[i_b_addr];
  end
end

endmodule

/* File: core/hrap_port.v */
// Purpose: host access port to the unit's internal ram
// Assumes: host-side logic shares i_clk_sys; mode jumper is a pin
// Notes: two-word block transfers or four-word i/o-word handshake
//
// Operation
// - The access scheme is picked by the front jumper level.
// - Two-word mode lets block instructions move many ram words.
// - Two-word transfers run when the instruction runs, no refresh.
// - A multi-word block write takes its first word as ram address.
// - Four-word mode reaches ram only through allocated i/o words; our AXI register window reaches it too.
// - Each four-word transaction moves exactly one ram word.
// - Four-word i/o words are sampled and updated only at refresh.
// - Host write-done raises our read-done; its drop drops ours.
// - A read puts data in word2 with write-done until host acks.
// - A one-word block write loads the read pointer for reads.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "hrap_consts.vh"
module hrap_port #(
  parameter DW = `HRAP_DATA_W,
  parameter AW = `HRAP_ADDR_W,
  parameter CW = `HRAP_CNT_W,
  parameter FD = `HRAP_FIFO_DEPTH,
  parameter FPW = `HRAP_FIFO_PW
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_resetn,
  // mode jumper, high selects four-word mode
  input wire i_mode_four,
  // two-word block instruction
  input wire i_blk_valid,
  output wire o_blk_ready,
  input wire i_blk_write,
  input wire [CW-1:0] i_blk_count,
  output wire o_blk_done,
  // block write words
  input wire i_wr_valid,
  input wire [DW-1:0] i_wr_data,
  output wire o_wr_ready,
  // block read words
  output wire o_rd_valid,
  output wire [DW-1:0] o_rd_data,
  input wire i_rd_ready,
  // four-word allocated i/o words
  input wire i_refresh,
  input wire [DW-1:0] i_io_w0,
  input wire [DW-1:0] i_io_w1,
  output wire [DW-1:0] o_io_w2,
  output reg [DW-1:0] o_io_w3,
  // axi4-lite slave
  input wire [`HRAP_AXI_AW-1:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  output wire [1:0] o_s_axi_bresp,
  output wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [`HRAP_AXI_AW-1:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  output wire [31:0] o_s_axi_rdata,
  output wire [1:0] o_s_axi_rresp,
  output wire o_s_axi_rvalid,
  input wire i_s_axi_rready
);

localparam [2:0] T_IDLE = 3'h0;
localparam [2:0] T_PTR = 3'h1;
localparam [2:0] T_ADDR = 3'h2;
localparam [2:0] T_WR = 3'h3;
localparam [2:0] T_RDREQ = 3'h4;
localparam [2:0] T_RDLD = 3'h5;
localparam [2:0] T_RDOUT = 3'h6;

localparam [2:0] F_IDLE = 3'h0;
localparam [2:0] F_ACK = 3'h1;
localparam [2:0] F_RDGET = 3'h2;
localparam [2:0] F_RDPUB = 3'h3;
localparam [2:0] F_RDWAIT = 3'h4;
localparam [2:0] F_RDCLR = 3'h5;

////////////////////////////////////////////////////////////////////////
// mode jumper: two-stage synchroniser, latched while reset is held

reg mode_s1_r;
reg mode_s2_r;
reg mode_four_r;

always @(posedge i_clk_sys) begin
  mode_s1_r <= i_mode_four;
  mode_s2_r <= mode_s1_r;
end

// a jumper may not change the scheme mid-operation, only across reset
always @(posedge i_clk_sys) begin
  if (!i_resetn) begin
    mode_four_r <= mode_s2_r;
  end
end

////////////////////////////////////////////////////////////////////////
// shared resources

reg ctrl_en_r;
reg [AW-1:0] ram_addr_r;
wire f_valid;
wire f_ready;
wire [DW-1:0] f_data;
wire [DW-1:0] a_q;
wire [DW-1:0] b_q;
reg a_we;
reg [AW-1:0] a_addr;
reg [DW-1:0] a_wdata;
wire b_we;

hrap_fifo #(.DW(DW), .DEPTH(FD), .PW(FPW)) u_fifo (
  .i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn),
  .i_in_valid(i_wr_valid),
  .o_in_ready(o_wr_ready),
  .i_in_data(i_wr_data),
  .o_out_valid(f_valid),
  .i_out_ready(f_ready),
  .o_out_data(f_data)
);

hrap_ram #(.DW(DW), .AW(AW)) u_ram (
  .i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn),
  .i_a_we(a_we),
  .i_a_addr(a_addr),
  .i_a_wdata(a_wdata),
  .o_a_rdata(a_q),
  .i_b_we(b_we),
  .i_b_addr(ram_addr_r),
  .i_b_wdata(i_s_axi_wdata[DW-1:0]),
  .o_b_rdata(b_q)
);

////////////////////////////////////////////////////////////////////////
// two-word mode: block transfers run as soon as the instruction arrives

reg [2:0] t_state_r;
reg [CW-1:0] t_cnt_r;
reg [AW-1:0] t_addr_r;
reg [AW-1:0] rptr_r;
reg rd_valid_r;
reg [DW-1:0] rd_data_r;
reg blk_done_r;
wire blk_take;

assign o_blk_ready = (t_state_r == T_IDLE) && !mode_four_r && ctrl_en_r;
assign blk_take = i_blk_valid && o_blk_ready;
assign f_ready = (t_state_r == T_PTR) || (t_state_r == T_ADDR) ||
                 (t_state_r == T_WR);
assign o_rd_valid = rd_valid_r;
assign o_rd_data = rd_data_r;
assign o_blk_done = blk_done_r;

always @(posedge i_clk_sys) begin
  if (!i_resetn) begin
    t_state_r <= T_IDLE;
    t_cnt_r <= {CW{1'b0}};
    t_addr_r <= {AW{1'b0}};
    rptr_r <= {AW{1'b0}};
    rd_valid_r <= 1'b0;
    rd_data_r <= {DW{1'b0}};
    blk_done_r <= 1'b0;
  end else begin
    blk_done_r <= 1'b0;
    case (t_state_r)
      T_IDLE: begin
        if (blk_take) begin
          t_cnt_r <= i_blk_count;
          t_addr_r <= rptr_r;
          if (i_blk_count == {CW{1'b0}}) begin
            blk_done_r <= 1'b1;
          end else if (!i_blk_write) begin
            t_state_r <= T_RDREQ;
          end else if (i_blk_count == {{(CW-1){1'b0}}, 1'b1}) begin
            t_state_r <= T_PTR;
          end else begin
            t_cnt_r <= i_blk_count - 1'b1;
            t_state_r <= T_ADDR;
          end
        end
      end
      T_PTR: begin
        if (f_valid) begin
          rptr_r <= f_data[AW-1:0];
          blk_done_r <= 1'b1;
          t_state_r <= T_IDLE;
        end
      end
      T_ADDR: begin
        if (f_valid) begin
          t_addr_r <= f_data[AW-1:0];
          t_state_r <= T_WR;
        end
      end
      T_WR: begin
        if (f_valid) begin
          t_addr_r <= t_addr_r + 1'b1;
          t_cnt_r <= t_cnt_r - 1'b1;
          if (t_cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
            blk_done_r <= 1'b1;
            t_state_r <= T_IDLE;
          end
        end
      end
      T_RDREQ: begin
        t_state_r <= T_RDLD;
      end
      T_RDLD: begin
        rd_data_r <= a_q;
        rd_valid_r <= 1'b1;
        t_state_r <= T_RDOUT;
      end
      T_RDOUT: begin
        if (i_rd_ready) begin
          rd_valid_r <= 1'b0;
          t_addr_r <= t_addr_r + 1'b1;
          t_cnt_r <= t_cnt_r - 1'b1;
          if (t_cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
            blk_done_r <= 1'b1;
            t_state_r <= T_IDLE;
          end else begin
            t_state_r <= T_RDREQ;
          end
        end
      end
      default: t_state_r <= T_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// four-word mode: one word per handshake, stepped at i/o refresh except the F_RDGET ram fetch

reg [2:0] f_state_r;
reg f_dir_r;
reg [AW-1:0] f_addr_r;
reg [DW-1:0] w2_stage_r;
reg [DW-1:0] w2_r;
reg fl_rdone_r;
reg fl_wdone_r;
wire f_go;
wire host_wdone;
wire host_rdone;
wire [AW-1:0] host_addr;

// the host holds these fields; we only look on refresh cycles
assign f_go = i_refresh && mode_four_r && ctrl_en_r;
assign host_wdone = i_io_w1[`HRAP_W1_WDONE];
assign host_rdone = i_io_w1[`HRAP_W1_RDONE];
assign host_addr = i_io_w1[`HRAP_W1_ADDR_LSB +: AW];
assign o_io_w2 = w2_r;

always @(posedge i_clk_sys) begin
  if (!i_resetn) begin
    f_state_r <= F_IDLE;
    f_dir_r <= 1'b0;
    f_addr_r <= {AW{1'b0}};
    w2_stage_r <= {DW{1'b0}};
    w2_r <= {DW{1'b0}};
    fl_rdone_r <= 1'b0;
    fl_wdone_r <= 1'b0;
  end else begin
    case (f_state_r)
      F_IDLE: begin
        if (f_go && host_wdone) begin
          f_dir_r <= i_io_w1[`HRAP_W1_DIR];
          f_addr_r <= host_addr;
          fl_rdone_r <= 1'b1;
          f_state_r <= F_ACK;
        end
      end
      F_ACK: begin
        if (f_go && !host_wdone) begin
          fl_rdone_r <= 1'b0;
          f_state_r <= f_dir_r ? F_IDLE : F_RDGET;
        end
      end
      F_RDGET: begin
        w2_stage_r <= a_q;
        f_state_r <= F_RDPUB;
      end
      F_RDPUB: begin
        if (f_go) begin
          w2_r <= w2_stage_r;
          fl_wdone_r <= 1'b1;
          f_state_r <= F_RDWAIT;
        end
      end
      F_RDWAIT: begin
        if (f_go && host_rdone) begin
          fl_wdone_r <= 1'b0;
          f_state_r <= F_RDCLR;
        end
      end
      F_RDCLR: begin
        if (f_go && !host_rdone) begin
          f_state_r <= F_IDLE;
        end
      end
      default: f_state_r <= F_IDLE;
    endcase
  end
end

always @* begin
  o_io_w3 = {DW{1'b0}};
  o_io_w3[`HRAP_W3_RDONE] = fl_rdone_r;
  o_io_w3[`HRAP_W3_WDONE] = fl_wdone_r;
end

// port a belongs wholly to whichever scheme the jumper picked
always @* begin
  a_we = 1'b0;
  a_addr = t_addr_r;
  a_wdata = f_data;
  if (mode_four_r) begin
    a_addr = (f_state_r == F_IDLE) ? host_addr : f_addr_r;
    a_wdata = i_io_w0;
    a_we = (f_state_r == F_IDLE) && f_go && host_wdone &&
           i_io_w1[`HRAP_W1_DIR];
  end else begin
    a_we = (t_state_r == T_WR) && f_valid;
  end
end

////////////////////////////////////////////////////////////////////////
// axi4-lite register slave

reg aw_got_r;
reg w_got_r;
reg [`HRAP_AXI_AW-1:0] awaddr_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
reg bvalid_r;
reg [1:0] bresp_r;
reg rpend_r;
reg rvalid_r;
reg [`HRAP_AXI_AW-1:0] araddr_r;
reg [31:0] rdata_r;
reg [1:0] rresp_r;
reg [31:0] rd_word;
reg [1:0] rd_resp;
wire wr_fire;

assign o_s_axi_awready = !aw_got_r && !bvalid_r;
assign o_s_axi_wready = !w_got_r && !bvalid_r;
assign o_s_axi_bvalid = bvalid_r;
assign o_s_axi_bresp = bresp_r;
assign o_s_axi_arready = !rpend_r && !rvalid_r;
assign o_s_axi_rvalid = rvalid_r;
assign o_s_axi_rdata = rdata_r;
assign o_s_axi_rresp = rresp_r;
assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
// a ram word is written only when both low byte lanes are enabled
assign b_we = wr_fire && (awaddr_r == `HRAP_REG_RDATA) &&
              (wstrb_r[1:0] == 2'b11);

always @* begin
  rd_word = 32'h0000_0000;
  rd_resp = `HRAP_RESP_OKAY;
  case (araddr_r)
    `HRAP_REG_CTRL: rd_word[`HRAP_CTRL_EN] = ctrl_en_r;
    `HRAP_REG_STAT: begin
      rd_word[`HRAP_STAT_MODE] = mode_four_r;
      rd_word[`HRAP_STAT_BUSY] = (t_state_r != T_IDLE) ||
                                 (f_state_r != F_IDLE);
      rd_word[`HRAP_STAT_FEMPTY] = !f_valid;
      rd_word[`HRAP_STAT_PTR_LSB +: AW] = rptr_r;
    end
    `HRAP_REG_RADDR: rd_word[AW-1:0] = ram_addr_r;
    `HRAP_REG_RDATA: rd_word[DW-1:0] = b_q;
    default: rd_resp = `HRAP_RESP_SLVERR;
  endcase
end

always @(posedge i_clk_sys) begin
  if (!i_resetn) begin
    aw_got_r <= 1'b0;
    w_got_r <= 1'b0;
    awaddr_r <= {`HRAP_AXI_AW{1'b0}};
    wdata_r <= 32'h0000_0000;
    wstrb_r <= 4'h0;
    bvalid_r <= 1'b0;
    bresp_r <= `HRAP_RESP_OKAY;
    ctrl_en_r <= `HRAP_CTRL_EN_RST;
    ram_addr_r <= {AW{1'b0}};
  end else begin
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_got_r <= 1'b1;
      awaddr_r <= i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_got_r <= 1'b1;
      wdata_r <= i_s_axi_wdata;
      wstrb_r <= i_s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b1;
      bresp_r <= `HRAP_RESP_OKAY;
      case (awaddr_r)
        `HRAP_REG_CTRL: begin
          if (wstrb_r[0]) begin
            ctrl_en_r <= wdata_r[`HRAP_CTRL_EN];
          end
        end
        `HRAP_REG_STAT: bresp_r <= `HRAP_RESP_OKAY;
        `HRAP_REG_RADDR: begin
          if (wstrb_r[0]) begin
            ram_addr_r <= wdata_r[AW-1:0];
          end
        end
        `HRAP_REG_RDATA: begin
          if (b_we) begin
            ram_addr_r <= ram_addr_r + 1'b1;
          end
        end
        default: bresp_r <= `HRAP_RESP_SLVERR;
      endcase
    end else if (bvalid_r && i_s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
end

// ram read of port b lands one cycle after the address is taken
always @(posedge i_clk_sys) begin
  if (!i_resetn) begin
    rpend_r <= 1'b0;
    rvalid_r <= 1'b0;
    araddr_r <= {`HRAP_AXI_AW{1'b0}};
    rdata_r <= 32'h0000_0000;
    rresp_r <= `HRAP_RESP_OKAY;
  end else begin
    rpend_r <= 1'b0;
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      araddr_r <= i_s_axi_araddr;
      rpend_r <= 1'b1;
    end
    if (rpend_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_resp;
    end else if (rvalid_r && i_s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
end

endmodule

/* File: tb/hrap_port_properties.sv */
// Purpose: concurrent checks on the host ram access port pins
// Assumes: the mode jumper only moves while reset is low
// Notes: bound to every hrap_port instance
`timescale 1ns/1ps
module hrap_port_chk (
  // clock and reset
  input wire i_clk_sys,
  input wire i_resetn,
  // block instruction side
  input wire i_mode_four,
  input wire i_blk_valid,
  input wire o_blk_ready,
  input wire [7:0] i_blk_count,
  input wire o_blk_done,
  // allocated i/o words
  input wire i_refresh,
  input wire [15:0] i_io_w1,
  input wire [15:0] o_io_w2,
  input wire [15:0] o_io_w3
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////////////////////
  w2_at_refresh_a: assert property (
    !i_refresh |=> $stable(o_io_w2)) else $error("word two moved off refresh");
  w3_at_refresh_a: assert property (
    !i_refresh |=> $stable(o_io_w3))
    else $error("word three moved off refresh");
  four_no_block_a: assert property (
    i_mode_four |-> !o_blk_ready) else $error("block taken in four-word mode");
  two_word_quiet_a: assert property (
    !i_mode_four |-> o_io_w3 == 16'h0000)
    else $error("flags in two-word mode");
  w3_spare_zero_a: assert property (
    (o_io_w3 & 16'hff3f) == 16'h0000) else $error("spare word three bits set");
  rdone_rise_a: assert property (
    $rose(o_io_w3[6]) |-> $past(i_refresh) && $past(i_io_w1[6]))
    else $error("read-done raised without host write-done");
  rdone_fall_a: assert property (
    $fell(o_io_w3[6]) |-> $past(i_refresh) && !$past(i_io_w1[6]))
    else $error("read-done dropped while host bit high");
  wdone_rise_a: assert property (
    $rose(o_io_w3[7]) |-> $past(i_refresh) && !o_io_w3[6])
    else $error("write-done raised out of order");
  wdone_fall_a: assert property (
    $fell(o_io_w3[7]) |-> $past(i_refresh) && $past(i_io_w1[7]))
    else $error("write-done dropped without host read-done");
  zero_count_a: assert property (
    i_blk_valid && o_blk_ready && i_blk_count == 8'h00 |-> ##[1:2] o_blk_done)
    else $error("empty block instruction never finished");
  done_pulse_a: assert property (
    o_blk_done |=> !o_blk_done) else $error("done longer than one cycle");
endmodule
bind hrap_port hrap_port_chk u_chk (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_mode_four(i_mode_four),
  .i_blk_valid(i_blk_valid), .o_blk_ready(o_blk_ready),
  .i_blk_count(i_blk_count), .o_blk_done(o_blk_done),
  .i_refresh(i_refresh), .i_io_w1(i_io_w1), .o_io_w2(o_io_w2),
  .o_io_w3(o_io_w3)
);

/* File: tb/hrap_host_model.sv */
// Purpose: controller cpu side of the four-word i/o word handshake
// Assumes: shares the port clock; refresh every fourth cycle
// Notes: one transaction at a time, called from the bench
`timescale 1ns/1ps
module hrap_host_model (
  // clock
  input wire i_clk_sys,
  // allocated i/o words
  output logic o_refresh,
  output logic [15:0] o_io_w0,
  output logic [15:0] o_io_w1,
  input wire [15:0] i_io_w2,
  input wire [15:0] i_io_w3
);
  logic [1:0] cyc_r;
  // handshakes that never saw the awaited flag; the bench checks it
  int n_late;
  initial begin
    cyc_r = 2'h0;
    n_late = 0;
    o_refresh = 1'b0;
    o_io_w0 = 16'h0000;
    o_io_w1 = 16'h0000;
  end
  always @(posedge i_clk_sys) begin
    cyc_r <= cyc_r + 2'h1;
    o_refresh <= (cyc_r == 2'h3);
  end
  ////////////////////////////////////////////////////////////////////////////
  // flags only move at refresh, so the wait must span several refreshes
  task await(input int b, input logic v);
    int k;
    k = 0;
    do begin
      @(negedge i_clk_sys);
      k++;
    end while (i_io_w3[b] !== v && k < 200);
    if (i_io_w3[b] !== v) n_late++;
    @(posedge i_clk_sys);
  endtask
  task fw_write(input logic [7:0] a, input logic [15:0] d);
    o_io_w0 <= d;
    o_io_w1 <= {a, 8'h41};
    await(6, 1'b1);
    o_io_w1 <= {a, 8'h01};
    await(6, 1'b0);
    // word no longer meaningful, so show garbage rather than stale data
    o_io_w0 <= ~d;
  endtask
  task fw_read(input logic [7:0] a, output logic [15:0] d);
    o_io_w1 <= {a, 8'h40};
    await(6, 1'b1);
    o_io_w1 <= {a, 8'h00};
    await(7, 1'b1);
    d = i_io_w2;
    o_io_w1 <= {a, 8'h80};
    await(7, 1'b0);
    o_io_w1 <= {a, 8'h00};
    repeat (8) @(posedge i_clk_sys);
  endtask
endmodule

/* File: tb/host_ram_access_port_tb_top.sv */
// Purpose: self-checking bench for the host ram access port
// Assumes: 100 MHz clock, jumper changed only under reset
// Notes: block words first fill the buffer, then the instruction runs
`timescale 1ns/1ps
`include "hrap_consts.vh"
module host_ram_access_port_tb_top;
  logic clk, rstn, mode, blk_valid, blk_write, wr_valid, rd_ready;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] blk_count;
  logic [15:0] wr_data, rv;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0] wstrb;
  logic [1:0] r;
  wire blk_ready, blk_done, wr_ready, rd_valid, refresh, awready, wready;
  wire bvalid, arready, rvalid;
  wire [15:0] rd_data, w0, w1, w2, w3;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [15:0] rq[$];
  int n_fail, cmp_count, i;
  hrap_port dut (
    .i_clk_sys(clk), .i_resetn(rstn), .i_mode_four(mode),
    .i_blk_valid(blk_valid), .o_blk_ready(blk_ready),
    .i_blk_write(blk_write), .i_blk_count(blk_count), .o_blk_done(blk_done),
    .i_wr_valid(wr_valid), .i_wr_data(wr_data), .o_wr_ready(wr_ready),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_rd_ready(rd_ready),
    .i_refresh(refresh), .i_io_w0(w0), .i_io_w1(w1), .o_io_w2(w2),
    .o_io_w3(w3), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready)
  );
  hrap_host_model host (
    .i_clk_sys(clk), .o_refresh(refresh), .o_io_w0(w0), .o_io_w1(w1),
    .i_io_w2(w2), .i_io_w3(w3)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task do_reset;
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask
  task axi_wr(input logic [4:0] a, input logic [31:0] v);
    logic pa, pw, ha, hw, hb;
    logic [1:0] rb;
    int k;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    hb = 1'b0;
    for (k = 0; k < 100 && !hb; k++) begin
      @(negedge clk);
      ha = pa && awready;
      hw = pw && wready;
      hb = !pa && !pw && bvalid;
      rb = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      pa = pa && !ha;
      pw = pw && !hw;
    end
    bready <= 1'b0;
    if (!hb) n_fail++;
    chk(32'(rb), 32'(`HRAP_RESP_OKAY));
    @(posedge clk);
  endtask
  task axi_rd(input logic [4:0] a, output logic [31:0] v,
              output logic [1:0] rs);
    logic pa, ha, hb;
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    hb = 1'b0;
    for (k = 0; k < 100 && !hb; k++) begin
      @(negedge clk);
      ha = pa && arready;
      hb = !pa && rvalid;
      v = rdata;
      rs = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      pa = pa && !ha;
    end
    rready <= 1'b0;
    if (!hb) n_fail++;
    @(posedge clk);
  endtask
  task push(input logic [15:0] v);
    logic h;
    int k;
    wr_valid <= 1'b1;
    wr_data <= v;
    h = 1'b0;
    for (k = 0; k < 100 && !h; k++) begin
      @(negedge clk);
      h = wr_ready;
      @(posedge clk);
    end
    wr_valid <= 1'b0;
    if (!h) n_fail++;
    @(posedge clk);
  endtask
  // read words are collected while waiting for the done pulse
  task blk(input logic w, input logic [7:0] n);
    logic h;
    int k;
    blk_valid <= 1'b1;
    blk_write <= w;
    blk_count <= n;
    rq.delete();
    h = 1'b0;
    for (k = 0; k < 100 && !h; k++) begin
      @(negedge clk);
      h = blk_ready;
      @(posedge clk);
    end
    blk_valid <= 1'b0;
    if (!h) n_fail++;
    h = 1'b0;
    for (k = 0; k < 500 && !h; k++) begin
      @(negedge clk);
      h = blk_done;
      if (rd_valid && rd_ready) rq.push_back(rd_data);
      @(posedge clk);
    end
    if (!h) n_fail++;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // a full run needs a few hundred cycles; this limit leaves ample slack
  initial begin
    #200000;
    n_fail++;
    print_verdict;
  end
  initial begin
    {rstn, mode, blk_valid, blk_write, wr_valid} = 5'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {blk_count, wr_data, awaddr, araddr, wdata} = '0;
    rd_ready = 1'b1;
    wstrb = 4'hf;
    do_reset;
    axi_rd(`HRAP_REG_CTRL, d, r);
    chk(d, 32'h1);
    axi_rd(`HRAP_REG_STAT, d, r);
    chk(32'(d[2:0]), 32'h4);
    axi_rd(5'h10, d, r);
    chk(32'(r), 32'(`HRAP_RESP_SLVERR));
    chk(d, 32'h0);
    blk(1'b1, 8'h00);
    for (i = 0; i < 8; i++) push(i == 0 ? 16'h0020 : 16'h1a00 + 16'(i));
    @(negedge clk);
    chk(32'(wr_ready), 32'h0);
    @(posedge clk);
    blk(1'b1, 8'h08);
    axi_rd(`HRAP_REG_STAT, d, r);
    chk(32'(d[2]), 32'h1);
    push(16'h0020);
    blk(1'b1, 8'h01);
    axi_rd(`HRAP_REG_STAT, d, r);
    chk(32'(d[15:8]), 32'h20);
    blk(1'b0, 8'h07);
    chk(32'(rq.size()), 32'h7);
    for (i = 0; i < 7; i++) chk(32'(rq[i]), 32'h1a01 + i);
    axi_wr(`HRAP_REG_RADDR, 32'h23);
    axi_rd(`HRAP_REG_RDATA, d, r);
    chk(d, 32'h1a04);
    // a window write stores the low half-word and steps the address
    axi_wr(`HRAP_REG_RDATA, 32'h0000_c0de);
    axi_rd(`HRAP_REG_RADDR, d, r);
    chk(d, 32'h24);
    axi_wr(`HRAP_REG_CTRL, 32'h0);
    @(negedge clk);
    chk(32'(blk_ready), 32'h0);
    @(posedge clk);
    axi_wr(`HRAP_REG_CTRL, 32'h1);
    mode <= 1'b1;
    do_reset;
    axi_rd(`HRAP_REG_STAT, d, r);
    chk(32'(d[0]), 32'h1);
    @(negedge clk);
    chk(32'(blk_ready), 32'h0);
    @(posedge clk);
    host.fw_write(8'h40, 16'hbeef);
    host.fw_write(8'h41, 16'h5a5a);
    host.fw_read(8'h40, rv);
    chk(32'(rv), 32'hbeef);
    host.fw_read(8'h41, rv);
    chk(32'(rv), 32'h5a5a);
    axi_wr(`HRAP_REG_RADDR, 32'h40);
    axi_rd(`HRAP_REG_RDATA, d, r);
    chk(d, 32'hbeef);
    host.fw_read(8'h23, rv);
    chk(32'(rv), 32'hc0de);
    chk(32'(host.n_late), 32'h0);
    print_verdict;
  end
endmodule
